// ---- dual_channel_fade_toggle_ctrl_test.sv ----
// testbench for the two-channel fade toggle controller
`timescale 1ns/1ps
module dual_channel_fade_toggle_ctrl_test;
    logic       clk = 0, rst_n = 0, sel = 1, shrt = 0;
    logic [1:0] press = 0, tgl;
    logic [2:0] flt = 0;
    logic [7:0] c1, c2;
    logic       fault;
    int         error_cnt = 0, samples_checked = 0, n;
    logic [7:0] m;
    toggle_src src_u (.clk_in(clk), .press_in(press), .short_in(shrt),
                      .toggle_out(tgl));
    fade_toggle_ctrl #(.DEBOUNCE_CYC(4), .FADE_STEP_CYC(3)) dut_u (
        .sys_clk_in(clk), .rst_n_in(rst_n), .chan1_toggle_in(tgl[0]),
        .chan2_toggle_in(tgl[1]), .fade_time_select_in(sel),
        .out_short_in(flt[2]), .iset_short_in(flt[1]),
        .over_temp_in(flt[0]), .chan1_current_out(c1),
        .chan2_current_out(c2), .fault_out(fault));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic check8(input string s, input logic [7:0] e, g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s exp %h got %h", s, e, g);
        end
    endtask : check8
    task automatic check1(input string s, input logic e, g);
        check8(s, {7'h00, e}, {7'h00, g});
    endtask : check1
    task automatic push(input int i);
        @(posedge clk); #1 press[i] = 1;
        @(posedge clk); #1 press = 0;
    endtask : push
    task automatic wait_lvl(input int ch, input logic [7:0] v,
                            input int max, output int k);
        k = 0;
        while ((ch ? c2 : c1) !== v && k < max) begin
            @(posedge clk); #1 k++;
        end
    endtask : wait_lvl
    task automatic give_verdict;
        $display("mismatches %0d comparisons %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict
    localparam int SLEW_LO = fade_pkg::SLEW_MIN_NS * fade_pkg::CLK_MHZ / 1000;
    localparam int SLEW_HI = fade_pkg::SLEW_MAX_NS * fade_pkg::CLK_MHZ / 1000;
    task automatic sc_reset_idle;
        check8("ch1 after reset", 8'h00, c1);
        check8("ch2 after reset", 8'h00, c2);
        check1("fault after reset", 1'b0, fault);
    endtask : sc_reset_idle
    task automatic sc_bounce;
        // bounce shorter than the debounce window
        shrt = 1;
        push(0);
        shrt = 0;
        repeat (40) @(posedge clk);
        #1;
        check8("ch1 after bounce", 8'h00, c1);
    endtask : sc_bounce
    task automatic sc_up_down;
        push(0);
        wait_lvl(0, 8'hFF, 400, n);
        check8("ch1 up", 8'hFF, c1);
        check1("up gradual", 1'b1, n >= 63);
        check8("ch2 untouched", 8'h00, c2);
        push(0);
        wait_lvl(0, 8'h00, 400, n);
        check8("ch1 down", 8'h00, c1);
        check1("down gradual", 1'b1, n >= 63);
    endtask : sc_up_down
    task automatic sc_reverse;
        // reverse in mid-fade: must come back from the middle
        push(0);
        repeat (60) @(posedge clk);
        #1 m = c1;
        check1("mid level", 1'b1, m != 8'h00 && m != 8'hFF);
        push(0);
        wait_lvl(0, 8'h00, 400, n);
        check8("ch1 reversed", 8'h00, c1);
        check1("no jump", 1'b1, n >= 30 && n < 150);
    endtask : sc_reverse
    task automatic sc_instant;
        sel = 0;
        push(1);
        wait_lvl(1, 8'hFF, 12000, n);
        check8("ch2 instant", 8'hFF, c2);
        check1("slew time", 1'b1, n >= SLEW_LO && n <= SLEW_HI);
        check8("ch1 untouched", 8'h00, c1);
    endtask : sc_instant
    task automatic sc_faults;
        for (int i = 0; i < 3; i++) begin
            flt = 3'h1 << i;
            repeat (8) @(posedge clk);
            #1;
            check1("fault flag", 1'b1, fault);
            check8("ch2 forced off", 8'h00, c2);
            flt = 0;
            repeat (8) @(posedge clk);
            #1;
            check1("fault clear", 1'b0, fault);
            check8("ch2 stays off", 8'h00, c2);
        end
    endtask : sc_faults
    task automatic sc_mid_reset;
        sel = 1;
        push(0);
        repeat (40) @(posedge clk);
        #1;
        check1("ch1 rising", 1'b1, c1 != 8'h00);
        rst_n = 0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1;
        check8("ch1 in reset", 8'h00, c1);
        repeat (20) @(posedge clk);
        #1;
        check8("ch1 off after reset", 8'h00, c1);
    endtask : sc_mid_reset
    // watchdog: about two and a half times the longest expected run
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        give_verdict();
    end
    initial begin
        repeat (2) @(posedge clk);
        #1 rst_n = 1;
        sc_reset_idle();
        sc_bounce();
        sc_up_down();
        sc_reverse();
        sc_instant();
        sc_faults();
        sc_mid_reset();
        give_verdict();
    end
endmodule : dual_channel_fade_toggle_ctrl_test

// ---- fade_pkg.sv ----
// constants for the dual channel fade toggle controller
package fade_pkg;
    localparam int unsigned CLK_MHZ        = 100;
    localparam int unsigned STEP_COUNT     = 63;
    localparam int unsigned IDX_W          = 6;
    localparam int unsigned LVL_W          = 8;
    // instant-switch slew time in ns (least, typical, most)
    localparam int unsigned SLEW_MIN_NS    = 45000;
    localparam int unsigned SLEW_TYP_NS    = 70000;
    localparam int unsigned SLEW_MAX_NS    = 100000;
    // instant mode: the whole zero-to-full walk takes the typical slew time
    localparam int unsigned SLEW_TYP_CYC   = SLEW_TYP_NS * CLK_MHZ / 1000;
    localparam int unsigned SLEW_STEP_CYC  = SLEW_TYP_CYC / STEP_COUNT;
    localparam int unsigned DEBOUNCE_CYC   = 100000;
    localparam int unsigned FADE_STEP_CYC  = 200000;
    localparam logic [5:0]  IDX_ZERO       = 6'h00;
    localparam logic [5:0]  IDX_FULL       = 6'h3F;

    // gamma curve, index 0..63 to a level 0..255
    function automatic logic [7:0] gamma_lut(input logic [5:0] idx);
        int unsigned sq;
        sq = (int'(idx) * int'(idx) * 255) / (63 * 63);
        return sq[7:0];
    endfunction : gamma_lut
endpackage : fade_pkg

// ---- fade_toggle_ctrl.sv ----
// two-channel debounced toggle with gamma fade and fault shutdown
`timescale 1ns/1ps
module fade_toggle_ctrl #(
    parameter int unsigned DEBOUNCE_CYC  = fade_pkg::DEBOUNCE_CYC,
    parameter int unsigned FADE_STEP_CYC = fade_pkg::FADE_STEP_CYC
) (
    // clock and reset
    input  wire logic       sys_clk_in,
    input  wire logic       rst_n_in,
    // toggle pins, asynchronous
    input  wire logic       chan1_toggle_in,
    input  wire logic       chan2_toggle_in,
    // fade timing select: low means fade bypassed
    input  wire logic       fade_time_select_in,
    // fault detectors, asynchronous
    input  wire logic       out_short_in,
    input  wire logic       iset_short_in,
    input  wire logic       over_temp_in,
    // current level per channel, and the fault flag
    output logic [7:0]      chan1_current_out,
    output logic [7:0]      chan2_current_out,
    output logic            fault_out
);
    localparam int unsigned CW = 32;

    // every assertion below runs on the one system clock
    default clocking cb_sys @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    if (DEBOUNCE_CYC < 2 || FADE_STEP_CYC < 1
        || fade_pkg::SLEW_STEP_CYC < 1) begin : g_bad_param
        $error("fade_toggle_ctrl: bad period parameter");
    end

    // synchronisers: first stage read only by the second
    // reset to the idle pin level, so no false press follows reset
    logic [5:0] sync1_q, sync2_q;
    logic [5:0] pins;
    assign pins = {over_temp_in, iset_short_in, out_short_in,
                   fade_time_select_in, chan2_toggle_in, chan1_toggle_in};
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            sync1_q <= 6'h00;
            sync2_q <= 6'h00;
        end else begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
        end
    end

    logic fade_en, fault;
    assign fade_en = sync2_q[2];
    assign fault   = |sync2_q[5:3];

    // shared step tick: one rate for both channels and both directions
    logic [CW-1:0] tick_cnt_q, tick_cnt_d;
    logic          tick;
    logic [CW-1:0] tick_max;
    always_comb begin
        // bypass keeps the same walk, only faster, so both modes share it
        if (fade_en)
            tick_max = CW'(FADE_STEP_CYC - 1);
        else
            tick_max = CW'(fade_pkg::SLEW_STEP_CYC - 1);
        // >= so a switch to the short period ticks at once, never wraps
        tick       = (tick_cnt_q >= tick_max);
        tick_cnt_d = tick ? '0 : tick_cnt_q + CW'(1);
    end
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) tick_cnt_q <= '0;
        else           tick_cnt_q <= tick_cnt_d;
    end

    // per-channel debounce, target and fade index
    logic             deb_q [2];
    logic             deb_d [2];
    logic             on_q [2];
    logic             on_d [2];
    logic             accept [2];
    logic [CW-1:0]    dcnt_q [2];
    logic [CW-1:0]    dcnt_d [2];
    logic [5:0]       idx_q [2];
    logic [5:0]       idx_d [2];

    generate
        for (genvar c = 0; c < 2; c++) begin : g_chan
            always_comb begin
                deb_d[c]  = deb_q[c];
                dcnt_d[c] = '0;
                accept[c] = 1'b0;
                if (sync2_q[c] != deb_q[c]) begin
                    dcnt_d[c] = dcnt_q[c] + CW'(1);
                    if (dcnt_q[c] >= CW'(DEBOUNCE_CYC - 1)) begin
                        deb_d[c]  = sync2_q[c];
                        dcnt_d[c] = '0;
                        // press edge only, so a held level toggles once
                        accept[c] = sync2_q[c];
                    end
                end
                on_d[c] = on_q[c];
                if (accept[c])
                    on_d[c] = ~on_q[c];
                if (fault)
                    on_d[c] = 1'b0;
                idx_d[c] = idx_q[c];
                if (fault)
                    idx_d[c] = fade_pkg::IDX_ZERO;
                else if (tick) begin
                    // step from wherever the walk stands
                    if (on_q[c] && idx_q[c] != fade_pkg::IDX_FULL)
                        idx_d[c] = idx_q[c] + 6'h01;
                    else if (!on_q[c] && idx_q[c] != fade_pkg::IDX_ZERO)
                        idx_d[c] = idx_q[c] - 6'h01;
                end
            end
            always_ff @(posedge sys_clk_in) begin
                if (!rst_n_in) begin
                    deb_q[c]  <= 1'b0;
                    dcnt_q[c] <= '0;
                    on_q[c]   <= 1'b0;
                    idx_q[c]  <= fade_pkg::IDX_ZERO;
                end else begin
                    deb_q[c]  <= deb_d[c];
                    dcnt_q[c] <= dcnt_d[c];
                    on_q[c]   <= on_d[c];
                    idx_q[c]  <= idx_d[c];
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            chan1_current_out <= 8'h00;
            chan2_current_out <= 8'h00;
            fault_out         <= 1'b0;
        end else begin
            chan1_current_out <= fade_pkg::gamma_lut(idx_q[0]);
            chan2_current_out <= fade_pkg::gamma_lut(idx_q[1]);
            fault_out         <= fault;
        end
    end

    a_toggle_flips: assert property (
        accept[0] && !fault |=> on_q[0] != $past(on_q[0]))
        else $error("accepted toggle did not flip channel 1");

    a_step_up_one: assert property (
        tick && on_q[1] && !fault && idx_q[1] != fade_pkg::IDX_FULL
        |=> idx_q[1] == $past(idx_q[1]) + 6'h01)
        else $error("up fade did not step by one");

    a_step_down_one: assert property (
        tick && !on_q[0] && !fault && idx_q[0] != fade_pkg::IDX_ZERO
        |=> idx_q[0] == $past(idx_q[0]) - 6'h01)
        else $error("down fade did not step by one");

    a_full_holds: assert property (
        on_q[0] && !fault && idx_q[0] == fade_pkg::IDX_FULL
        |=> idx_q[0] == fade_pkg::IDX_FULL)
        else $error("full level did not hold");

    // the output register lags the index by exactly one cycle
    a_level_follows: assert property (
        1'b1 |=> chan2_current_out == fade_pkg::gamma_lut($past(idx_q[1])))
        else $error("channel 2 level does not track its index");

    a_debounce_hold: assert property (
        $changed(deb_q[1]) |-> $past(sync2_q[1]) == deb_q[1]
        && $past(dcnt_q[1]) >= CW'(DEBOUNCE_CYC - 1))
        else $error("debounced state changed early");

    a_bounce_ignored: assert property (
        sync2_q[0] == deb_q[0] |=> dcnt_q[0] == '0 && $stable(deb_q[0]))
        else $error("debounce counter ran on a steady pin");

    a_fast_rate: assert property (
        !fade_en && $past(!fade_en) && tick
        |-> tick_cnt_q == CW'(fade_pkg::SLEW_STEP_CYC - 1))
        else $error("bypass step period wrong");

    a_hold_still: assert property (
        !tick && !fault |=> $stable(idx_q[0]) && $stable(idx_q[1]))
        else $error("index moved without step tick");

    a_no_cross_talk: assert property (
        accept[0] && !accept[1] && !fault |=> $stable(on_q[1]))
        else $error("channel 2 changed by channel 1 toggle");

    a_cross_talk_back: assert property (
        accept[1] && !accept[0] && !fault |=> $stable(on_q[0]))
        else $error("channel 1 changed by channel 2 toggle");

    a_fault_off: assert property (
        fault |=> ##1 chan1_current_out == 8'h00
        && chan2_current_out == 8'h00)
        else $error("fault did not zero outputs");

    a_fault_stops: assert property (
        fault |=> !on_q[0] && !on_q[1] && fault_out)
        else $error("fault left a channel on or unflagged");

    a_no_jump: assert property (
        !fault |=> idx_q[0] == $past(idx_q[0])
        || idx_q[0] == $past(idx_q[0]) + 6'h01
        || idx_q[0] == $past(idx_q[0]) - 6'h01)
        else $error("channel 1 index jumped");
endmodule : fade_toggle_ctrl

// ---- toggle_src.sv ----
// momentary pushbutton model driving both toggle pins
`timescale 1ns/1ps
module toggle_src #(
    parameter int unsigned HOLD = 8
) (
    input  wire logic       clk_in,
    input  wire logic [1:0] press_in,
    input  wire logic       short_in,
    output logic [1:0]      toggle_out
);
    int unsigned cnt [2] = '{0, 0};
    // short pulse models contact bounce that must be filtered
    always @(posedge clk_in) begin
        for (int i = 0; i < 2; i++) begin
            if (press_in[i]) cnt[i] <= short_in ? 2 : HOLD;
            else if (cnt[i] != 0) cnt[i] <= cnt[i] - 1;
        end
    end
    always_comb toggle_out = {cnt[1] != 0, cnt[0] != 0};
endmodule : toggle_src
